//--- ipc_pkg.sv
package ipc_pkg;
  // geometry
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned NUM_SRC = 64;
  localparam int unsigned SRC_W = 6;
  localparam int unsigned LVL_REGS = 7;
  localparam int unsigned FLD_PER_REG = 8;
  localparam int unsigned NUM_FLD = LVL_REGS * FLD_PER_REG;
  localparam int unsigned VBA_W = 14;
  localparam int unsigned VEC_ADDR_W = 21;
  localparam int unsigned FHI_W = 5;
  ////////////////////////////////////////////////////////////////////////////
  // register offsets, in bus words
  localparam logic [4:0] OFF_LEVELS_0 = 5'h00;
  localparam logic [4:0] OFF_VBA = 5'h07;
  localparam logic [4:0] OFF_FMATCH_0 = 5'h08;
  localparam logic [4:0] OFF_FLOW_0 = 5'h09;
  localparam logic [4:0] OFF_FHIGH_0 = 5'h0a;
  localparam logic [4:0] OFF_FMATCH_1 = 5'h0b;
  localparam logic [4:0] OFF_FLOW_1 = 5'h0c;
  localparam logic [4:0] OFF_FHIGH_1 = 5'h0d;
  localparam logic [4:0] OFF_PEND_0 = 5'h0e;
  localparam logic [4:0] OFF_PEND_3 = 5'h11;
  localparam logic [4:0] OFF_CTRL = 5'h16;
  ////////////////////////////////////////////////////////////////////////////
  // writable-bit masks and reset value
  localparam logic [15:0] RESET_VAL = 16'h0000;
  localparam logic [15:0] MASK_ALL = 16'hffff;
  localparam logic [15:0] MASK_LEVELS_0 = 16'hf3ff;
  localparam logic [15:0] MASK_LEVELS_6 = 16'h0fff;
  localparam logic [15:0] MASK_VBA = 16'h3fff;
  localparam logic [15:0] MASK_FMATCH = 16'h003f;
  localparam logic [15:0] MASK_FHIGH = 16'h001f;
  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int unsigned SYNTH_LO = 14;
  localparam int unsigned LOWV_LO = 12;
  localparam int unsigned DBGRX_LO = 8;
  localparam int unsigned CTRL_ACTIVE = 15;
  localparam int unsigned CTRL_CODE_LO = 13;
  localparam int unsigned CTRL_VAB_LO = 6;
  localparam int unsigned CTRL_BLOCK = 5;
  localparam logic [15:0] CTRL_ONES = 16'h001c;
  ////////////////////////////////////////////////////////////////////////////
  // level codes
  localparam logic [1:0] LEVEL_OFF = 2'h0;
  localparam logic [1:0] LEVEL_TWO = 2'h2;
  localparam logic [1:0] PLC_NONE = 2'h0;
  localparam logic [1:0] PLC_P0 = 2'h1;
  localparam logic [1:0] PLC_P1 = 2'h2;
  localparam logic [1:0] PLC_P23 = 2'h3;
  // fields whose codes mean levels 1..3 (the first register); rest 0..2
  localparam logic [55:0] HIGH_RANGE_DEF = 56'h0000_0000_0000_00ff;
endpackage

//--- ipc_controller.sv
`timescale 1ns/1ps
`default_nettype none
module ipc_controller #(
  parameter logic [55:0] HIGH_RANGE_MAP = ipc_pkg::HIGH_RANGE_DEF
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [ipc_pkg::NUM_SRC-1:0] irq_req,
  input wire logic [ipc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [ipc_pkg::DATA_W-1:0] reg_wdata,
  output logic [ipc_pkg::DATA_W-1:0] reg_rdata,
  output logic core_irq,
  output logic [1:0] core_level,
  output logic [1:0] presented_level_code,
  output logic [ipc_pkg::SRC_W-1:0] core_vector,
  output logic [ipc_pkg::VEC_ADDR_W-1:0] core_vec_addr,
  output logic core_fast,
  output logic wake_req
);
  import ipc_pkg::*;

  // {enable, level} from a 2-bit field; low range shifts codes down by one
  function automatic logic [2:0] decode_lvl(input logic [1:0] code,
                                            input logic high);
    logic [1:0] lv;
    lv = high ? code : 2'(code - 2'h1);
    decode_lvl = {code != LEVEL_OFF, lv};
  endfunction

  // writable bits of a level register index
  function automatic logic [15:0] lvl_mask(input int unsigned idx);
    if (idx == 0)
      lvl_mask = MASK_LEVELS_0;
    else if (idx == LVL_REGS - 1)
      lvl_mask = MASK_LEVELS_6;
    else
      lvl_mask = MASK_ALL;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // register file
  logic [15:0] lvl_r [LVL_REGS];
  logic [15:0] lvl_nxt [LVL_REGS];
  logic [15:0] vba_r, vba_nxt;
  logic [15:0] fm0_r, fm0_nxt, fl0_r, fl0_nxt, fh0_r, fh0_nxt;
  logic [15:0] fm1_r, fm1_nxt, fl1_r, fl1_nxt, fh1_r, fh1_nxt;
  logic block_r, block_nxt;
  logic [15:0] rdata_nxt;
  logic [NUM_SRC-1:0] pend_r;

  // masked writes; reserved bits never store, so they read zero, except CTRL bits 4:2, which read one
  always_comb begin
    for (int i = 0; i < LVL_REGS; i++) begin
      lvl_nxt[i] = lvl_r[i];
      if (reg_wr_en && reg_addr == 5'(OFF_LEVELS_0 + 5'(i)))
        lvl_nxt[i] = reg_wdata & lvl_mask(i);
    end
    vba_nxt = vba_r;
    fm0_nxt = fm0_r;
    fl0_nxt = fl0_r;
    fh0_nxt = fh0_r;
    fm1_nxt = fm1_r;
    fl1_nxt = fl1_r;
    fh1_nxt = fh1_r;
    block_nxt = block_r;
    if (reg_wr_en) begin
      unique case (reg_addr)
        OFF_VBA: vba_nxt = reg_wdata & MASK_VBA;
        OFF_FMATCH_0: fm0_nxt = reg_wdata & MASK_FMATCH;
        OFF_FLOW_0: fl0_nxt = reg_wdata;
        OFF_FHIGH_0: fh0_nxt = reg_wdata & MASK_FHIGH;
        OFF_FMATCH_1: fm1_nxt = reg_wdata & MASK_FMATCH;
        OFF_FLOW_1: fl1_nxt = reg_wdata;
        OFF_FHIGH_1: fh1_nxt = reg_wdata & MASK_FHIGH;
        OFF_CTRL: block_nxt = reg_wdata[CTRL_BLOCK];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < LVL_REGS; i++)
        lvl_r[i] <= RESET_VAL;
      vba_r <= RESET_VAL;
      fm0_r <= RESET_VAL;
      fl0_r <= RESET_VAL;
      fh0_r <= RESET_VAL;
      fm1_r <= RESET_VAL;
      fl1_r <= RESET_VAL;
      fh1_r <= RESET_VAL;
      block_r <= 1'b0;
    end else begin
      for (int i = 0; i < LVL_REGS; i++)
        lvl_r[i] <= lvl_nxt[i];
      vba_r <= vba_nxt;
      fm0_r <= fm0_nxt;
      fl0_r <= fl0_nxt;
      fh0_r <= fh0_nxt;
      fm1_r <= fm1_nxt;
      fl1_r <= fl1_nxt;
      fh1_r <= fh1_nxt;
      block_r <= block_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-source enable and level; field f sits at bits 15-2p of register f/8
  logic [NUM_SRC-1:0] src_en;
  logic [1:0] src_lvl [NUM_SRC];
  logic [NUM_SRC-1:0] pend_now;

  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g++) begin : g_src
      if (g < NUM_FLD) begin : g_fld
        localparam int unsigned RI = g / FLD_PER_REG;
        localparam int unsigned LO = SYNTH_LO - 2 * (g % FLD_PER_REG);
        logic [2:0] dec;
        assign dec = decode_lvl(lvl_r[RI][LO+:2], HIGH_RANGE_MAP[g]);
        assign src_en[g] = dec[2];
        assign src_lvl[g] = dec[1:0];
      end else begin : g_nofld
        // no level field: held off permanently
        assign src_en[g] = 1'b0;
        assign src_lvl[g] = LEVEL_OFF;
      end
    end
  endgenerate

  // disabled sources are masked before arbitration and wake-up
  assign pend_now = irq_req & src_en;

  ////////////////////////////////////////////////////////////////////////////
  // arbitration: highest level first, lowest number within a level
  logic win_valid;
  logic [1:0] win_lvl;
  logic [SRC_W-1:0] win_src;
  logic [3:0] lvl_any;
  logic [SRC_W-1:0] lvl_src [4];

  always_comb begin
    lvl_any = 4'h0;
    for (int l = 0; l < 4; l++)
      lvl_src[l] = '0;
    // downward scan so the lowest number overwrites last
    for (int s = NUM_SRC - 1; s >= 0; s--) begin
      if (pend_now[s]) begin
        lvl_any[src_lvl[s]] = 1'b1;
        lvl_src[src_lvl[s]] = SRC_W'(s);
      end
    end
    win_valid = |lvl_any;
    win_lvl = 2'h0;
    win_src = lvl_src[0];
    for (int l = 1; l < 4; l++) begin
      if (lvl_any[l]) begin
        win_lvl = 2'(l);
        win_src = lvl_src[l];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // vector address: fast target on a level-2 match, else base-relative
  logic fast0, fast1;
  logic [VEC_ADDR_W-1:0] addr_sel;
  logic [VEC_ADDR_W-1:0] addr_normal;

  assign addr_normal = {vba_r[VBA_W-1:0], 1'b0, win_src};
  assign fast0 = win_lvl == LEVEL_TWO && win_src == fm0_r[SRC_W-1:0];
  assign fast1 = win_lvl == LEVEL_TWO && win_src == fm1_r[SRC_W-1:0];

  // match 0 takes precedence when both fast registers hold the same number
  always_comb begin
    if (fast0)
      addr_sel = {fh0_r[FHI_W-1:0], fl0_r};
    else if (fast1)
      addr_sel = {fh1_r[FHI_W-1:0], fl1_r};
    else
      addr_sel = addr_normal;
  end

  ////////////////////////////////////////////////////////////////////////////
  // core-facing outputs, registered
  logic irq_nxt, fast_nxt, wake_nxt;
  logic [1:0] plc_nxt;

  // blocking stops presentation but still lets a pending request wake
  always_comb begin
    irq_nxt = win_valid && !block_r;
    fast_nxt = irq_nxt && (fast0 || fast1);
    wake_nxt = |pend_now;
    if (!irq_nxt)
      plc_nxt = PLC_NONE;
    else if (win_lvl == 2'h0)
      plc_nxt = PLC_P0;
    else if (win_lvl == 2'h1)
      plc_nxt = PLC_P1;
    else
      plc_nxt = PLC_P23;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      core_irq <= 1'b0;
      core_level <= 2'h0;
      presented_level_code <= PLC_NONE;
      core_vector <= '0;
      core_vec_addr <= '0;
      core_fast <= 1'b0;
      wake_req <= 1'b0;
      pend_r <= '0;
    end else begin
      core_irq <= irq_nxt;
      core_level <= win_lvl;
      presented_level_code <= plc_nxt;
      core_vector <= win_src;
      core_vec_addr <= addr_sel;
      core_fast <= fast_nxt;
      wake_req <= wake_nxt;
      pend_r <= pend_now;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port: data one cycle after reg_rd_en, unmapped reads zero
  always_comb begin
    rdata_nxt = '0;
    if (reg_addr < OFF_VBA)
      rdata_nxt = lvl_r[reg_addr[2:0]];
    else if (reg_addr >= OFF_PEND_0 && reg_addr <= OFF_PEND_3)
      rdata_nxt = pend_r[DATA_W*(reg_addr - OFF_PEND_0) +: DATA_W];
    else begin
      unique case (reg_addr)
        OFF_VBA: rdata_nxt = vba_r;
        OFF_FMATCH_0: rdata_nxt = fm0_r;
        OFF_FLOW_0: rdata_nxt = fl0_r;
        OFF_FHIGH_0: rdata_nxt = fh0_r;
        OFF_FMATCH_1: rdata_nxt = fm1_r;
        OFF_FLOW_1: rdata_nxt = fl1_r;
        OFF_FHIGH_1: rdata_nxt = fh1_r;
        OFF_CTRL: begin
          rdata_nxt = CTRL_ONES;
          rdata_nxt[CTRL_ACTIVE] = core_irq;
          rdata_nxt[CTRL_CODE_LO+:2] = presented_level_code;
          rdata_nxt[CTRL_VAB_LO+:7] = core_vec_addr[6:0];
          rdata_nxt[CTRL_BLOCK] = block_r;
        end
        default: rdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      reg_rdata <= '0;
    else if (reg_rd_en)
      reg_rdata <= rdata_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  logic seen_edge_r;
  logic lower_hit;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      seen_edge_r <= 1'b0;
    else
      seen_edge_r <= 1'b1;
  end

  // any lower-numbered pending source at the winner's level
  always_comb begin
    lower_hit = 1'b0;
    for (int s = 0; s < NUM_SRC; s++)
      if (pend_now[s] && src_lvl[s] == win_lvl && SRC_W'(s) < win_src)
        lower_hit = 1'b1;
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  chk_reset_clear: assert property (!seen_edge_r |-> lvl_r[0] == RESET_VAL)
    else $error("first level register not zero after reset");
  chk_synth_write: assert property (
    reg_wr_en && reg_addr == OFF_LEVELS_0 |=>
      lvl_r[0][SYNTH_LO+:2] == $past(reg_wdata[SYNTH_LO+:2]))
    else $error("synth lock level field not stored");
  chk_lowv_write: assert property (
    reg_wr_en && reg_addr == OFF_LEVELS_0 |=>
      lvl_r[0][LOWV_LO+:2] == $past(reg_wdata[LOWV_LO+:2]))
    else $error("low voltage level field not stored");
  chk_dbgrx_write: assert property (
    reg_wr_en && reg_addr == OFF_LEVELS_0 |=>
      lvl_r[0][DBGRX_LO+:2] == $past(reg_wdata[DBGRX_LO+:2]))
    else $error("debug receive level field not stored");
  chk_rsvd_zero: assert property (lvl_r[0][11:10] == 2'h0)
    else $error("reserved bits of first level register set");
  chk_level_map: assert property (
    core_irq && core_vector == '0 |->
      core_level == $past(lvl_r[0][SYNTH_LO+:2]))
    else $error("synth request presented at wrong level");
  chk_lowest_wins: assert property (win_valid |-> !lower_hit)
    else $error("higher number chosen within a level");
  chk_off_silent: assert property (
    core_irq |-> $past(src_en[win_src] && irq_req[win_src]))
    else $error("disabled request presented to core");
  chk_normal_addr: assert property (
    core_irq && !core_fast |->
      core_vec_addr == {$past(vba_r[VBA_W-1:0]), 1'b0, core_vector})
    else $error("normal vector address wrong");
  chk_fast_level: assert property (
    core_fast |-> core_level == LEVEL_TWO && core_irq && core_vec_addr ==
      ($past(fm0_r[SRC_W-1:0]) == core_vector ?
        $past({fh0_r[FHI_W-1:0], fl0_r}) :
        $past({fh1_r[FHI_W-1:0], fl1_r})))
    else $error("fast vector address or level wrong");

  cov_fast: cover property (core_fast && core_irq);
  cov_top_level: cover property (core_irq && core_level == 2'h3);
  cov_blocked_wake: cover property (block_r && wake_req && !core_irq);
  cov_two_levels: cover property (lvl_any[0] && lvl_any[2]);
endmodule
`default_nettype wire

//--- ipc_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// stand-in for the core: notes each newly presented interrupt
module ipc_core_model (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic core_irq,
  input wire logic [ipc_pkg::VEC_ADDR_W-1:0] core_vec_addr,
  output logic [7:0] taken_cnt,
  output logic [ipc_pkg::VEC_ADDR_W-1:0] last_addr
);
  import ipc_pkg::*;
  logic irq_d_r;
  // a level held high is one request, so only rising edges are taken
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq_d_r <= 1'b0;
      taken_cnt <= '0;
      last_addr <= '0;
    end else begin
      irq_d_r <= core_irq;
      if (core_irq && !irq_d_r) begin
        taken_cnt <= taken_cnt + 8'h01;
        last_addr <= core_vec_addr;
      end
    end
  end
endmodule
`default_nettype wire

//--- tb_interrupt_priority_controller.sv
`timescale 1ns/1ps
`default_nettype none
module tb_interrupt_priority_controller;
  import ipc_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n;
  logic [63:0] irq_req;
  logic [4:0] reg_addr;
  logic reg_wr_en;
  logic reg_rd_en;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic core_irq;
  logic [1:0] core_level;
  logic [1:0] presented_level_code;
  logic [5:0] core_vector;
  logic [20:0] core_vec_addr;
  logic core_fast;
  logic wake_req;
  logic [7:0] taken_cnt;
  logic [20:0] last_addr;
  logic [15:0] d;
  int n_errors = 0;
  int samples_checked = 0;
  ////////////////////////////////////////////////////////////////////////////
  ipc_controller u_ipc_controller (.clk_sys(clk_sys), .rst_n(rst_n),
    .irq_req(irq_req), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .core_irq(core_irq), .core_level(core_level),
    .presented_level_code(presented_level_code), .core_vector(core_vector),
    .core_vec_addr(core_vec_addr), .core_fast(core_fast),
    .wake_req(wake_req));
  ipc_core_model u_ipc_core_model (.clk_sys(clk_sys), .rst_n(rst_n),
    .core_irq(core_irq), .core_vec_addr(core_vec_addr),
    .taken_cnt(taken_cnt), .last_addr(last_addr));
  // 20 MHz system clock
  always #25 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////////////////////
  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // strobes drop one edge later, so back-to-back calls never collide
  task wr(input logic [4:0] a, input logic [15:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr_en <= 1'b1;
    @(posedge clk_sys);
    reg_wr_en <= 1'b0;
  endtask
  task rd(input logic [4:0] a, output logic [15:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd_en <= 1'b1;
    @(posedge clk_sys);
    reg_rd_en <= 1'b0;
    #1 v = reg_rdata;
  endtask
  // new request pattern, then let the registered outputs settle
  task req(input logic [63:0] r);
    @(posedge clk_sys);
    irq_req <= r;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask
  task results();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task t_reset();
    rd(OFF_LEVELS_0, d);
    chk("levels0 reset", d, RESET_VAL);
    req('1);
    chk("irq all off", core_irq, 1'b0);
    chk("wake all off", wake_req, 1'b0);
    req('0);
  endtask
  // every enabling code (1 to 3) on each of the three documented fields
  task automatic t_codes();
    int src[3] = '{0, 1, 3};
    int lo[3] = '{SYNTH_LO, LOWV_LO, DBGRX_LO};
    for (int f = 0; f < 3; f++) begin
      for (int c = 1; c < 4; c++) begin
        wr(OFF_LEVELS_0, 16'(c << lo[f]));
        req(64'h1 << src[f]);
        chk("level", core_level, c);
        chk("vector", core_vector, src[f]);
        chk("code", presented_level_code, c == 1 ? PLC_P1 : PLC_P23);
        req('0);
      end
    end
  endtask
  // reserved pair never stores, so source 2 stays dead
  task t_reserved();
    wr(OFF_LEVELS_0, 16'hffff);
    rd(OFF_LEVELS_0, d);
    chk("levels0 mask", d, MASK_LEVELS_0);
    req(64'h4);
    chk("src2 irq", core_irq, 1'b0);
    req('0);
  endtask
  task t_arbit();
    wr(OFF_VBA, 16'h1234);
    wr(OFF_LEVELS_0, 16'h7300);
    req(64'h0b);
    chk("win vector", core_vector, 6'h01);
    chk("win level", core_level, 2'h3);
    chk("vec addr", core_vec_addr, {14'h1234, 1'b0, 6'h01});
    chk("core saw", last_addr, {14'h1234, 1'b0, 6'h01});
    req(64'h09);
    chk("next vector", core_vector, 6'h03);
    req(64'h01);
    chk("low vector", core_vector, 6'h00);
    chk("low level", core_level, 2'h1);
    req('0);
  endtask
  task t_fast();
    wr(OFF_FMATCH_0, 16'h0003);
    wr(OFF_FLOW_0, 16'habcd);
    wr(OFF_FHIGH_0, 16'h0015);
    wr(OFF_LEVELS_0, 16'h0200);
    req(64'h08);
    chk("fast flag", core_fast, 1'b1);
    chk("fast addr", core_vec_addr, {5'h15, 16'habcd});
    wr(OFF_LEVELS_0, 16'h0300);
    req(64'h08);
    chk("lvl3 not fast", core_fast, 1'b0);
    chk("lvl3 addr", core_vec_addr, {14'h1234, 1'b0, 6'h03});
    // second fast set; match 0 moved away so match 1 alone hits
    wr(OFF_FMATCH_0, 16'h0005);
    wr(OFF_FMATCH_1, 16'h0003);
    wr(OFF_FLOW_1, 16'h1357);
    wr(OFF_FHIGH_1, 16'h000a);
    wr(OFF_LEVELS_0, 16'h0200);
    req(64'h08);
    chk("fast1 flag", core_fast, 1'b1);
    chk("fast1 addr", core_vec_addr, {5'h0a, 16'h1357});
    rd(OFF_PEND_0, d);
    chk("pending", d, 16'h0008);
    req('0);
  endtask
  // block bit hides requests from the core but not from wake-up
  task t_block();
    wr(OFF_LEVELS_0, 16'h0100);
    wr(OFF_CTRL, 16'h0020);
    req(64'h08);
    chk("blocked irq", core_irq, 1'b0);
    chk("blocked wake", wake_req, 1'b1);
    wr(OFF_CTRL, 16'h0000);
    req(64'h08);
    chk("unblocked irq", core_irq, 1'b1);
    wr(OFF_LEVELS_0, 16'h0000);
    req(64'h08);
    chk("off irq", core_irq, 1'b0);
    chk("off wake", wake_req, 1'b0);
    // blocked, reserved and disabled requests never reached the core
    chk("core takes", taken_cnt, 8'h0c);
    req('0);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    irq_req = '0;
    reg_addr = '0;
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_wdata = '0;
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset();
    t_codes();
    t_reserved();
    t_arbit();
    t_fast();
    t_block();
    results();
  end
  // whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk_sys);
    n_errors++;
    results();
  end
endmodule
`default_nettype wire
